// ==== rtl/flm_fault_log.sv ====
/*
  Fault log manager top: active list, history, occurrence counts, browsing.
  Assumes fault causes and keys are asynchronous pins, the time stamp is
  stable whole-second data from the real-time clock.
*/
// How it works
// - detected faults latch in the active list until an active reset.
// - every new fault is also appended to history, except one rising or still queued in a history clear cycle, and a repeat rise while queued.
// - history keeps the newest sixteen faults with time stamps.
// - history survives active reset and power loss; nonvolatile storage.
// - only the history clear command empties the history.
// - stamp holds month, day, year, hour, minute, second from time setting.
// - per fault type occurrence count since last history clear.
// - counts are presented most frequent first.
// - history clear empties history and all counts together.
// - active reset clears list; persisting causes still light fault indicator.
// - up and down keys step through entries of the selected list.
// - any active fault stops the drive and blocks new starts.
`timescale 1ns/1ps

module flm_fault_log
  import flm_pkg::*;
#(
  parameter int NUM = `FLM_NUM_FAULTS,
  parameter int ID_W = `FLM_FAULT_ID_W,
  parameter int CNT_W = `FLM_COUNT_W,
  parameter int PTR_W = `FLM_HIST_PTR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // fault causes, level per fault type
  input wire logic [NUM-1:0] faultCause,
  // real-time clock
  input wire flm_pkg::flm_stamp_t timeNow,
  // keypad
  input wire flm_pkg::flm_keys_t keys,
  input wire flm_pkg::flm_view_t viewSel,
  // drive control
  input wire logic runRequest,
  output logic runEnable,
  output logic faultIndicator,
  // display
  output logic [NUM-1:0] activeList,
  output flm_pkg::flm_display_t display
);
  import flm_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // causeD and keysD are the edge-detect stage, not part of the synchronisers
  logic [NUM-1:0] causeS1_reg, causeS2_reg, causeD_reg;
  flm_keys_t keysS1_reg, keysS2_reg, keysD_reg;
  logic runS1_reg, runS2_reg;
  logic [1:0] viewS1_reg, viewS2_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      causeS1_reg <= '0;
      causeS2_reg <= '0;
      causeD_reg <= '0;
      keysS1_reg <= '0;
      keysS2_reg <= '0;
      keysD_reg <= '0;
      runS1_reg <= 1'b0;
      runS2_reg <= 1'b0;
      viewS1_reg <= 2'h0;
      viewS2_reg <= 2'h0;
    end else begin
      causeS1_reg <= faultCause;
      causeS2_reg <= causeS1_reg;
      causeD_reg <= causeS2_reg;
      keysS1_reg <= keys;
      keysS2_reg <= keysS1_reg;
      keysD_reg <= keysS2_reg;
      runS1_reg <= runRequest;
      runS2_reg <= runS1_reg;
      viewS1_reg <= viewSel;
      viewS2_reg <= viewS1_reg;
    end
  end

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  // rising edges of causes and keys; keys act once per press
  wire logic [NUM-1:0] faultRise = causeS2_reg & ~causeD_reg;
  wire flm_keys_t keyPress = keysS2_reg & ~keysD_reg;
  wire logic stepUp = keyPress.keyUp;
  wire logic stepDown = keyPress.keyDown;
  wire logic activeReset = keyPress.activeResetCmd;
  wire logic histClear = keyPress.historyClearCmd;
  // the view code crosses as two bits; a torn code only restarts the cursor
  wire flm_view_t viewNow = flm_view_t'(viewS2_reg);

  // lowest pending or newly risen fault goes to history this cycle
  function automatic logic [ID_W-1:0] lowestSet(input logic [NUM-1:0] v);
    lowestSet = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowestSet = ID_W'(i);
      end
    end
  endfunction : lowestSet

  // ----------------------------------------
  // pending history pushes
  // ----------------------------------------
  // several faults rising together are queued bit-wise and logged one per cycle
  // a fault rising again while still queued is logged only once
  logic [NUM-1:0] pend_reg, pend_next;
  wire logic [NUM-1:0] pendAll = pend_reg | faultRise;
  wire logic pushValid = |pendAll;
  wire logic [ID_W-1:0] pushId = lowestSet(pendAll);

  always_comb begin
    pend_next = pendAll;
    if (pushValid) begin
      pend_next[pushId] = 1'b0;
    end
    // a clear also drops pushes still waiting
    if (histClear) begin
      pend_next = '0;
    end
  end

  // ----------------------------------------
  // active list
  // ----------------------------------------
  // a fault rising in the reset cycle is kept: set wins over clear
  logic [NUM-1:0] active_reg, active_next;
  assign active_next = (activeReset ? '0 : active_reg) | faultRise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      active_reg <= '0;
      pend_reg <= '0;
    end else begin
      active_reg <= active_next;
      pend_reg <= pend_next;
    end
  end

  // ----------------------------------------
  // history and counts
  // ----------------------------------------
  flm_hist_entry_t pushEntry, histEntry;
  logic [PTR_W:0] histFill;
  logic [PTR_W-1:0] histIdx;
  logic [ID_W-1:0] rankId;
  logic [CNT_W-1:0] rankCount;

  // declared here because the rank lookup is addressed by the cursor
  logic [ID_W-1:0] cursor_reg, cursor_next, cursorLimit;
  flm_view_t viewLast_reg;

  // the stamp is not synchronised: the clock bus must hold still across a push
  assign pushEntry = '{
    faultId: pushId,
    stamp: timeNow
  };

  // storage keeps its contents through rstn; only the clear command empties it
  flm_history_store #(
    .DEPTH(`FLM_HIST_DEPTH),
    .PTR_W(PTR_W)
  ) uHist (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pushValid(pushValid && !histClear),
    .pushEntry(pushEntry),
    .clearReq(histClear),
    .readIdx(histIdx),
    .readEntry(histEntry),
    .fillLevel(histFill)
  );

  // counts skip the clear cycle so a clear never leaves a stray count
  flm_count_sorter #(
    .NUM(NUM),
    .ID_W(ID_W),
    .CNT_W(CNT_W)
  ) uCount (
    .clk_sys(clk_sys),
    .newFault(faultRise & {NUM{!histClear}}),
    .clearReq(histClear),
    .rankIdx(cursor_reg),
    .rankId(rankId),
    .rankCount(rankCount)
  );

  // ----------------------------------------
  // browsing cursor
  // ----------------------------------------
  // nth set bit of the active list, for stepping through active faults
  function automatic logic [ID_W:0] nthActive(input logic [NUM-1:0] v,
                                             input logic [ID_W-1:0] n);
    int seen;
    seen = 0;
    nthActive = '0;
    for (int i = 0; i < NUM; i++) begin
      if (v[i]) begin
        if (ID_W'(seen) == n && seen < NUM) begin
          nthActive = {1'b1, ID_W'(i)};
        end
        seen = seen + 1;
      end
    end
  endfunction : nthActive

  // number of listed faults, which bounds the cursor in the active view
  function automatic logic [ID_W:0] popCount(input logic [NUM-1:0] v);
    popCount = '0;
    for (int i = 0; i < NUM; i++) begin
      popCount = popCount + (ID_W+1)'(v[i]);
    end
  endfunction : popCount

  wire logic [ID_W:0] activeCount = popCount(active_reg);

  // last index the cursor may reach; an empty list pins it at 0
  always_comb begin
    case (viewNow)
      FLM_VIEW_ACTIVE: cursorLimit = (activeCount == '0) ? '0 : ID_W'(activeCount - 1'b1);
      FLM_VIEW_HISTORY: cursorLimit = (histFill == '0) ? '0 : ID_W'(histFill - 1'b1);
      FLM_VIEW_COUNT: cursorLimit = ID_W'(NUM - 1);
      default: cursorLimit = '0;
    endcase
  end

  always_comb begin
    cursor_next = cursor_reg;
    if (viewNow != viewLast_reg) begin
      cursor_next = `FLM_CURSOR_RST;
    end else if (stepDown && cursor_reg < cursorLimit) begin
      cursor_next = cursor_reg + ID_W'(1);
    end else if (stepUp && cursor_reg != '0) begin
      cursor_next = cursor_reg - ID_W'(1);
    end else if (cursor_reg > cursorLimit) begin
      // a shrinking list pulls the cursor back onto its last entry
      cursor_next = cursorLimit;
    end
  end

  // history index 0 is the newest entry
  assign histIdx = cursor_reg[PTR_W-1:0];

  // ----------------------------------------
  // display and drive outputs
  // ----------------------------------------
  // display lags the cursor by one cycle
  flm_display_t disp_next;
  wire logic [ID_W:0] activePick = nthActive(active_reg, cursor_reg);

  always_comb begin
    disp_next = '0;
    case (viewNow)
      FLM_VIEW_ACTIVE: begin
        disp_next.valid = activePick[ID_W];
        disp_next.faultId = activePick[ID_W-1:0];
      end
      FLM_VIEW_HISTORY: begin
        disp_next.valid = ((PTR_W+1)'(cursor_reg) < histFill);
        disp_next.faultId = histEntry.faultId;
        disp_next.stamp = histEntry.stamp;
      end
      FLM_VIEW_COUNT: begin
        disp_next.valid = 1'b1;
        disp_next.faultId = rankId;
        disp_next.count = rankCount;
      end
      default: disp_next = '0;
    endcase
  end

  // ----------------------------------------
  // drive interlock
  // ----------------------------------------
  // persisting causes keep the indicator lit even after the list is cleared
  wire logic anyFault = (|active_reg) || (|causeS2_reg);
  // a cause still present after an active reset also keeps the drive stopped
  wire logic runOk = runS2_reg && !anyFault;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cursor_reg <= `FLM_CURSOR_RST;
      viewLast_reg <= FLM_VIEW_ACTIVE;
      display <= '0;
      activeList <= '0;
      faultIndicator <= 1'b0;
      runEnable <= 1'b0;
    end else begin
      cursor_reg <= cursor_next;
      viewLast_reg <= viewNow;
      display <= disp_next;
      activeList <= active_reg;
      faultIndicator <= anyFault;
      runEnable <= runOk;
    end
  end

endmodule : flm_fault_log

// ==== rtl/flm_params.svh ====
/*
  Constants of the fault log manager: sizes, limits and reset values.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef FLM_PARAMS_SVH
`define FLM_PARAMS_SVH

`define FLM_NUM_FAULTS 32
`define FLM_FAULT_ID_W 5
`define FLM_HIST_DEPTH 16
`define FLM_HIST_PTR_W 4
`define FLM_COUNT_W 16
`define FLM_COUNT_MAX 16'hffff
`define FLM_CURSOR_RST 5'h00
`define FLM_COUNT_RST 16'h0000

`endif

// ==== rtl/flm_pkg.sv ====
/*
  Types shared by the fault log manager modules.
  Assumes flm_params.svh is on the include path.
*/
`include "flm_params.svh"

package flm_pkg;

  // time of day as supplied by the real-time clock
  typedef struct packed {
    logic [3:0] month;
    logic [4:0] day;
    logic [6:0] year;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } flm_stamp_t;

  typedef struct packed {
    logic [`FLM_FAULT_ID_W-1:0] faultId;
    flm_stamp_t stamp;
  } flm_hist_entry_t;

  // keypad commands, one bit per key, held as levels on the pins
  typedef struct packed {
    logic keyUp;
    logic keyDown;
    logic activeResetCmd;
    logic historyClearCmd;
  } flm_keys_t;

  // which list the display walks through
  typedef enum logic [1:0] {
    FLM_VIEW_ACTIVE,
    FLM_VIEW_HISTORY,
    FLM_VIEW_COUNT
  } flm_view_t;

  typedef struct packed {
    logic valid;
    logic [`FLM_FAULT_ID_W-1:0] faultId;
    flm_stamp_t stamp;
    logic [`FLM_COUNT_W-1:0] count;
  } flm_display_t;

endpackage : flm_pkg

// ==== rtl/flm_history_store.sv ====
/*
  Sixteen-entry time-stamped fault history, circular, oldest overwritten.
  Assumes the storage array maps onto non-volatile cells; rstn does not touch
  the entries, so only a clear request empties it.
*/
`timescale 1ns/1ps

module flm_history_store
  import flm_pkg::*;
#(
  parameter int DEPTH = `FLM_HIST_DEPTH,
  parameter int PTR_W = `FLM_HIST_PTR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // write side
  input wire logic pushValid,
  input wire flm_pkg::flm_hist_entry_t pushEntry,
  input wire logic clearReq,
  // read side, index 0 is newest
  input wire logic [PTR_W-1:0] readIdx,
  output flm_pkg::flm_hist_entry_t readEntry,
  output logic [PTR_W:0] fillLevel
);
  import flm_pkg::*;

  flm_hist_entry_t histMem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W:0] fill_reg;
  wire logic [PTR_W-1:0] rdAddr = wrPtr_reg - PTR_W'(1) - readIdx;

  // entries carry no reset so that power cycles keep them
  always_ff @(posedge clk_sys) begin
    if (pushValid && rstn && !clearReq) begin
      histMem[wrPtr_reg] <= pushEntry;
    end
  end

  // pointer and fill live in the same non-volatile cells: rstn leaves them alone,
  // it only holds off pushes while the rest of the block is in reset
  always_ff @(posedge clk_sys) begin
    if (clearReq) begin
      wrPtr_reg <= '0;
      fill_reg <= '0;
    end else if (pushValid && rstn) begin
      wrPtr_reg <= wrPtr_reg + PTR_W'(1);
      if (fill_reg != (PTR_W+1)'(DEPTH)) begin
        fill_reg <= fill_reg + (PTR_W+1)'(1);
      end
    end
  end

  assign readEntry = histMem[rdAddr];
  assign fillLevel = fill_reg;

endmodule : flm_history_store

// ==== rtl/flm_count_sorter.sv ====
/*
  Per-fault occurrence counters and a rank lookup by descending count.
  Assumes counters sit in non-volatile cells; only the clear request zeroes them.
*/
`timescale 1ns/1ps

module flm_count_sorter
  import flm_pkg::*;
#(
  parameter int NUM = `FLM_NUM_FAULTS,
  parameter int ID_W = `FLM_FAULT_ID_W,
  parameter int CNT_W = `FLM_COUNT_W
) (
  // clock
  input wire logic clk_sys,
  // events
  input wire logic [NUM-1:0] newFault,
  input wire logic clearReq,
  // rank query, rank 0 is most frequent
  input wire logic [ID_W-1:0] rankIdx,
  output logic [ID_W-1:0] rankId,
  output logic [CNT_W-1:0] rankCount
);
  import flm_pkg::*;

  logic [CNT_W-1:0] count_reg [NUM];

  // i ranks above j when its count is larger, ties by lower id
  function automatic logic beats(input logic [CNT_W-1:0] ci, input logic [CNT_W-1:0] cj,
                                 input int i, input int j);
    beats = (ci > cj) || ((ci == cj) && (i < j));
  endfunction : beats

  for (genvar g = 0; g < NUM; g++) begin : gCnt
    always_ff @(posedge clk_sys) begin
      if (clearReq) begin
        count_reg[g] <= `FLM_COUNT_RST;
      end else if (newFault[g] && count_reg[g] != `FLM_COUNT_MAX) begin
        count_reg[g] <= count_reg[g] + CNT_W'(1);
      end
    end
  end

  // rank of each id = number of ids beating it; combinational select
  always_comb begin
    int rnk;
    rnk = 0;
    rankId = '0;
    rankCount = '0;
    for (int i = 0; i < NUM; i++) begin
      rnk = 0;
      for (int j = 0; j < NUM; j++) begin
        if (j != i && beats(count_reg[j], count_reg[i], j, i)) begin
          rnk = rnk + 1;
        end
      end
      if (ID_W'(rnk) == rankIdx) begin
        rankId = ID_W'(i);
        rankCount = count_reg[i];
      end
    end
  end

endmodule : flm_count_sorter

// ==== verification/flm_fault_log_chk.sv ====
/* Checker on the fault log top ports.
   Assumes the bind at the foot of this file. */
`timescale 1ns/1ps

module flm_fault_log_chk
  import flm_pkg::*;
#(
  parameter int NUM = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // inputs
  input wire logic [NUM-1:0] faultCause,
  input wire flm_pkg::flm_keys_t keys,
  input wire logic runRequest,
  // outputs
  input wire logic runEnable,
  input wire logic faultIndicator,
  input wire logic [NUM-1:0] activeList
);
  import flm_pkg::*;

  logic [7:0][NUM-1:0] causeHist;
  logic [7:0] runHist;
  logic [3:0] rstAge;
  logic [NUM-1:0] recentCause;

  // window of eight cycles covers sync and edge detect latency
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      causeHist <= '0;
      runHist <= '0;
      rstAge <= 4'hf;
    end else begin
      causeHist <= {causeHist[6:0], faultCause};
      runHist <= {runHist[6:0], runRequest};
      rstAge <= keys.activeResetCmd ? 4'h0 : ((rstAge == 4'hf) ? rstAge : rstAge + 4'h1);
    end
  end

  always_comb begin
    recentCause = '0;
    for (int i = 0; i < 8; i++) recentCause = recentCause | causeHist[i];
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_run_blocked: assert property ((|activeList) |-> !runEnable)
    else $error("run enabled with a fault listed");
  a_lamp_list: assert property ((|activeList) |-> faultIndicator)
    else $error("indicator dark with a fault listed");
  a_list_holds: assert property ((|($past(activeList) & ~activeList)) |-> (rstAge < 4'h8))
    else $error("listed fault dropped without reset key");
  a_no_phantom: assert property ((activeList & ~$past(activeList) & ~recentCause) == '0)
    else $error("fault listed without a cause");
  a_lamp_cause: assert property (faultIndicator |-> ((|activeList) || (|recentCause)))
    else $error("indicator lit with no fault");
  a_cause_lights: assert property ((|faultCause) [*6] |-> faultIndicator)
    else $error("persisting cause not indicated");
  a_run_needs_req: assert property (runEnable |-> (|runHist))
    else $error("run enabled without request");
  a_run_resumes: assert property (
    (runRequest && faultCause == '0 && activeList == '0) [*8] |-> runEnable)
    else $error("run not allowed when fault free");
  a_run_lamp: assert property (faultIndicator |-> !runEnable)
    else $error("run enabled while a fault is indicated");
endmodule : flm_fault_log_chk

bind flm_fault_log flm_fault_log_chk #(.NUM(NUM)) i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .faultCause(faultCause), .keys(keys),
  .runRequest(runRequest), .runEnable(runEnable), .faultIndicator(faultIndicator),
  .activeList(activeList)
);

// ==== verification/flm_keypad_model.sv ====
/* Keypad model: a one-cycle press request becomes a held key level.
   Assumes requests arrive at least 12 cycles apart. */
`timescale 1ns/1ps

module flm_keypad_model
  import flm_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // request from bench
  input wire flm_pkg::flm_keys_t pressReq,
  // keypad pins
  output flm_pkg::flm_keys_t keys
);
  flm_keys_t held = '0;
  int age = 12;

  // a press lasts a few cycles, then falls so the next press is a new edge
  always_ff @(posedge clk_sys) begin
    if (pressReq != '0) begin
      held <= pressReq;
      age <= 0;
    end else if (age < 12) begin
      age <= age + 1;
    end
  end

  assign keys = (age < 5) ? held : '0;
endmodule : flm_keypad_model

// ==== verification/test_fault_log_manager.sv ====
/* Self-checking bench for the fault log top.
   Assumes the checker binds itself and the keypad model drives keys. */
`timescale 1ns/1ps

module test_fault_log_manager;
  import flm_pkg::*;
  localparam flm_keys_t KUP = 4'h8;
  localparam flm_keys_t KDOWN = 4'h4;
  localparam flm_keys_t KRST = 4'h2;
  localparam flm_keys_t KCLR = 4'h1;
  logic clk_sys;
  logic rstn;
  logic [31:0] faultCause;
  flm_stamp_t timeNow;
  flm_keys_t pressReq;
  flm_keys_t keys;
  flm_view_t viewSel;
  logic runRequest;
  logic runEnable;
  logic faultIndicator;
  logic [31:0] activeList;
  flm_display_t display;
  int errors = 0;
  int comparisons = 0;
  int cnt[32];
  flm_hist_entry_t hist[$];
  logic [31:0] mask;

  flm_fault_log i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .faultCause(faultCause), .timeNow(timeNow),
    .keys(keys), .viewSel(viewSel), .runRequest(runRequest), .runEnable(runEnable),
    .faultIndicator(faultIndicator), .activeList(activeList), .display(display)
  );
  flm_keypad_model i_kpd (.clk_sys(clk_sys), .pressReq(pressReq), .keys(keys));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic press(input flm_keys_t k);
    pressReq <= k;
    tick(1);
    pressReq <= '0;
    tick(14);
  endtask : press

  // stamp held until the next fault, since the push samples it unsynced
  task automatic fault(input int f, input bit keep);
    flm_hist_entry_t e;
    e.faultId = 5'(f);
    e.stamp.month = 4'($urandom_range(12, 1));
    e.stamp.day = 5'($urandom_range(28, 1));
    e.stamp.year = 7'($urandom_range(99, 0));
    e.stamp.hour = 5'($urandom_range(23, 0));
    e.stamp.minute = 6'($urandom_range(59, 0));
    e.stamp.second = 6'($urandom_range(59, 0));
    timeNow <= e.stamp;
    faultCause[f] <= 1'b1;
    tick(8);
    hist.push_front(e);
    if (hist.size() > 16) void'(hist.pop_back());
    cnt[f]++;
    mask[f] = 1'b1;
    if (!keep) faultCause[f] <= 1'b0;
    tick(4);
  endtask : fault

  // leave and re-enter so the cursor starts at entry 0
  task automatic setView(input flm_view_t v);
    viewSel <= (v == FLM_VIEW_ACTIVE) ? FLM_VIEW_COUNT : FLM_VIEW_ACTIVE;
    tick(6);
    viewSel <= v;
    tick(8);
  endtask : setView

  task automatic checkHist();
    setView(FLM_VIEW_HISTORY);
    press(KDOWN);
    press(KUP);
    foreach (hist[i]) begin
      check("hist valid", 40'(display.valid), 40'h1);
      check("hist id", 40'(display.faultId), 40'(hist[i].faultId));
      check("hist stamp", 40'(display.stamp), 40'(hist[i].stamp));
      press(KDOWN);
    end
  endtask : checkHist

  // walk the active list from the lowest id upward
  task automatic checkActive();
    setView(FLM_VIEW_ACTIVE);
    for (int f = 0; f < 32; f++) begin
      if (mask[f]) begin
        check("active valid", 40'(display.valid), 40'h1);
        check("active id", 40'(display.faultId), 40'(f));
        press(KDOWN);
      end
    end
  endtask : checkActive

  task automatic checkRank(input int n);
    int c[32];
    int best;
    setView(FLM_VIEW_COUNT);
    c = cnt;
    for (int r = 0; r < n; r++) begin
      best = 0;
      for (int f = 1; f < 32; f++) if (c[f] > c[best]) best = f;
      check("rank id", 40'(display.faultId), 40'(best));
      check("rank count", 40'(display.count), 40'(c[best]));
      c[best] = -1;
      press(KDOWN);
    end
  endtask : checkRank

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    faultCause = '0;
    timeNow = '0;
    pressReq = '0;
    viewSel = FLM_VIEW_ACTIVE;
    runRequest = 1'b0;
    mask = '0;
    cnt = '{default: 0};
    void'($urandom(32'h74d7));
    tick(20);
    rstn <= 1'b1;
    tick(2);
    press(KCLR);
    runRequest <= 1'b1;
    tick(8);
    check("run idle", 40'(runEnable), 40'h1);
    fault(3, 1'b1);
    check("list first", 40'(activeList), 40'h8);
    check("run stopped", 40'(runEnable), 40'h0);
    faultCause[3] <= 1'b0;
    tick(8);
    check("list kept", 40'(activeList), 40'h8);
    for (int k = 0; k < 19; k++) fault($urandom_range(7, 0), 1'b0);
    check("list all", 40'(activeList), 40'(mask));
    checkActive();
    checkHist();
    checkRank(4);
    fault(9, 1'b1);
    press(KRST);
    check("list reset", 40'(activeList), 40'h0);
    check("lamp held", 40'(faultIndicator), 40'h1);
    check("run held", 40'(runEnable), 40'h0);
    faultCause[9] <= 1'b0;
    tick(10);
    check("lamp off", 40'(faultIndicator), 40'h0);
    check("run back", 40'(runEnable), 40'h1);
    checkHist();
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    tick(4);
    checkHist();
    press(KCLR);
    hist = {};
    cnt = '{default: 0};
    setView(FLM_VIEW_HISTORY);
    check("hist empty", 40'(display.valid), 40'h0);
    checkRank(2);
    end_of_test();
  end
endmodule : test_fault_log_manager
